// ==== core/sram_ctrl.sv ====
// async x16 sram controller: sequences read and write accesses on the pins
// Behaviour
// - write strobe stays high throughout every read access
// - read timing runs from last valid address to next address change
// - chip select held low at least 50 ns before write end
// - address stable 50 ns before write end, zero setup allowed
// - write data valid 25 ns before write end, zero hold
// - written byte enables asserted 50 ns before write end
// - address valid no later than chip select asserting in reads
// - controller avoids data bus contention on shared lines
// - write happens during overlap of chip select and write strobe
// - chip select or write strobe high whenever address changes
`timescale 1ns/1ps
`default_nettype none

module sram_ctrl
    import sram_ctrl_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire req_type           req,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output pins_type               pins,
    input  wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0]      data_lines_out,
    output logic [1:0]             data_lines_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // gray codes along idle, setup, access, recover; turn sits off the main path
    typedef enum logic [2:0] {
        IDLE    = 3'b000,
        SETUP   = 3'b001,
        ACCESS  = 3'b011,
        RECOVER = 3'b010,
        TURN    = 3'b110
    } state_type;

    // one counter serves turnaround, strobe window and read access
    localparam int CNT_W = 8;

    state_type           state;
    logic [CNT_W-1:0]    count;
    logic                is_write;
    logic                was_read;
    logic [1:0]          lanes;
    logic [DATA_W-1:0]   sync1;
    logic [DATA_W-1:0]   sync2;
    logic                accept;

    // the counter must reach every end point; wider figures need a wider counter
    if (READ_ACCESS_CYC + 2 >= (1 << CNT_W) || WRITE_CYCLE_CYC + 2 >= (1 << CNT_W)
        || TURN_CYC + 2 >= (1 << CNT_W)) begin : g_count_check
        $error("sram_ctrl: timing counts exceed counter width");
    end

    // end of the strobe window: writes run the pulse length, reads the access time plus one sample cycle
    function automatic logic access_done(input logic wr, input logic [CNT_W-1:0] c);
        return wr ? (c == CNT_W'(WRITE_LOW_CYC - 1)) : (c == CNT_W'(READ_ACCESS_CYC));
    endfunction

    // a new request is taken only from idle, so accesses never overlap
    assign req_ready = (state == IDLE);
    assign accept    = req_valid && req_ready;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // address is set up at least one cycle before any strobe falls and held at least two cycles after
    // all strobes rise, so it never moves under a live select or strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= IDLE;
            count    <= '0;
            is_write <= 1'b0;
            was_read <= 1'b0;
            lanes    <= 2'b00;
        end else begin
            unique case (state)
                IDLE: begin
                    if (accept) begin
                        is_write <= req.write;
                        lanes    <= req.lanes;
                        // a write right after a read waits for the memory to let go
                        state    <= (req.write && was_read) ? TURN : SETUP;
                        count    <= '0;
                    end
                end
                // turnaround covers the memory's worst float time after a read
                TURN: begin
                    if (count == CNT_W'(TURN_CYC - 1)) begin
                        state <= SETUP;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                // address has had a full cycle to settle before select falls
                SETUP: begin
                    state <= ACCESS;
                    count <= '0;
                end
                ACCESS: begin
                    if (access_done(is_write, count)) begin
                        state <= RECOVER;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                // strobes are already high; address stays put one more cycle
                RECOVER: begin
                    state    <= IDLE;
                    was_read <= !is_write;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // chip select and write strobe fall together, so the memory never turns its
    // outputs on during a write and the write spans exactly the strobe window
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pins <= PINS_IDLE;
        end else begin
            if (accept) begin
                pins.addr <= req.addr;
            end
            if (state == SETUP) begin
                pins.chip_select_n           <= 1'b0;
                pins.output_enable_n         <= is_write;
                pins.write_strobe_n          <= !is_write;
                pins.low_byte_lane_enable_n  <= !lanes[0];
                pins.high_byte_lane_enable_n <= !lanes[1];
            end else if (state == ACCESS && access_done(is_write, count)) begin
                // strobe length covers pulse width and all setups to write end
                pins.chip_select_n           <= 1'b1;
                pins.output_enable_n         <= 1'b1;
                pins.write_strobe_n          <= 1'b1;
                pins.low_byte_lane_enable_n  <= 1'b1;
                pins.high_byte_lane_enable_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // write data lanes
    // ------------------------------------------------------------
    // data is driven from access through recovery, giving zero-hold margin past write end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_lines_out <= '0;
            data_lines_oe  <= 2'b00;
        end else begin
            if (accept && req.write) begin
                data_lines_out <= req.wdata;
            end
            if (state == SETUP && is_write) begin
                data_lines_oe <= lanes;
            end else if (state == RECOVER || state == IDLE) begin
                data_lines_oe <= 2'b00;
            end
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    // data pins arrive from outside the clock domain, so two stages
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= data_lines_in;
            sync2 <= sync1;
        end
    end

    // taken in recovery: the two stages then show the pins as they stood 5 ns
    // past the chip-select access time; capturing one cycle sooner would see the pins
    // before select-to-data has run out when the address did not change
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rsp_rdata <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == RECOVER && !is_write) begin
                // unselected lanes read as zero
                rsp_rdata <= sync2 & {{8{lanes[1]}}, {8{lanes[0]}}};
                rsp_valid <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== core/sram_ctrl_pkg.sv ====
// package: pin groups, timing figures and cycle counts for the async sram controller
package sram_ctrl_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;

    // ------------------------------------------------------------
    // timing figures in ns (-55 grade)
    // ------------------------------------------------------------
    localparam int READ_CYCLE_NS      = 55;
    localparam int CS_ACCESS_NS       = 55;
    localparam int OE_ACCESS_NS       = 35;
    localparam int DESELECT_FLOAT_NS  = 25;
    localparam int WRITE_CYCLE_NS     = 55;
    localparam int CS_TO_WEND_NS      = 50;
    localparam int ADDR_TO_WEND_NS    = 50;
    localparam int WRITE_PULSE_NS     = 45;
    localparam int DATA_TO_WEND_NS    = 25;
    localparam int BYTE_TO_WEND_NS    = 50;
    localparam int WRITE_FLOAT_NS     = 25;

    // least times round up to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_of(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    // read: worst of chip-select and output-enable access; access_done adds the sample cycle
    localparam int READ_ACCESS_CYC = max_of(min_cycles(CS_ACCESS_NS), min_cycles(OE_ACCESS_NS));
    localparam int READ_CYCLE_CYC  = min_cycles(READ_CYCLE_NS);
    // write strobe low time covers pulse, cs, address, byte and data setup
    localparam int WRITE_LOW_CYC   = max_of(max_of(min_cycles(WRITE_PULSE_NS), min_cycles(CS_TO_WEND_NS)),
                                            max_of(min_cycles(ADDR_TO_WEND_NS),
                                                   max_of(min_cycles(BYTE_TO_WEND_NS),
                                                          min_cycles(DATA_TO_WEND_NS))));
    localparam int WRITE_CYCLE_CYC = min_cycles(WRITE_CYCLE_NS);
    // bus turnaround idle after a read before the controller drives data
    localparam int TURN_CYC        = max_of(min_cycles(DESELECT_FLOAT_NS), min_cycles(WRITE_FLOAT_NS));

    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // user request and pin groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic [1:0]        lanes;   // bit0 low byte, bit1 high byte
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_type;

    typedef struct packed {
        logic              chip_select_n;
        logic              output_enable_n;
        logic              write_strobe_n;
        logic              low_byte_lane_enable_n;
        logic              high_byte_lane_enable_n;
        logic [ADDR_W-1:0] addr;
    } pins_type;

    localparam pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}};

endpackage

// ==== verification/sram_ctrl_monitor.sv ====
// checker: pin sequencing assertions for the sram controller
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_monitor
    import sram_ctrl_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire req_type           req,
    input wire logic              rsp_valid,
    input wire pins_type          pins,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic [1:0]        data_lines_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // short aliases for the strobes
    wire       cs_n = pins.chip_select_n;
    wire       oe_n = pins.output_enable_n;
    wire       we_n = pins.write_strobe_n;
    wire [1:0] be_n = {pins.high_byte_lane_enable_n, pins.low_byte_lane_enable_n};
    property p_read_quiet; !oe_n |-> we_n && data_lines_oe == 2'b00; endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("strobe or data driven during read");
    property p_addr_move; $changed(pins.addr) |-> cs_n && $past(cs_n); endproperty
    a_addr_move: assert property (p_addr_move)
        else $error("address moved while selected");
    property p_pulse; $fell(we_n) |-> (!we_n && !cs_n)[*5] ##1 (we_n && cs_n); endproperty
    a_pulse: assert property (p_pulse)
        else $error("write pulse length wrong");
    property p_wr_hold; !we_n && !$past(we_n) |-> $stable(pins.addr) && $stable(be_n) && $stable(data_lines_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write inputs moved during pulse");
    property p_wr_lanes; !we_n |-> data_lines_oe == ~be_n; endproperty
    a_wr_lanes: assert property (p_wr_lanes)
        else $error("driven lanes differ from byte enables");
    property p_turn; $rose(oe_n) |-> (data_lines_oe == 2'b00)[*4]; endproperty
    a_turn: assert property (p_turn)
        else $error("data driven too soon after read");
    property p_rd_lat;
        req_valid && req_ready && !req.write |-> (!rsp_valid)[*8] ##1 (!rsp_valid)[*2] ##1 rsp_valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer at wrong cycle");
    property p_rd_start; $fell(oe_n) |-> $fell(cs_n) && we_n && $stable(pins.addr); endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read strobes out of order");
    c_read: cover property (req_valid && req_ready && !req.write);
    c_write: cover property (req_valid && req_ready && req.write);
    c_turn: cover property ($rose(oe_n) ##[1:12] $fell(we_n));
endmodule
bind sram_ctrl sram_ctrl_monitor mon (.ref_clk, .rstn, .req_valid, .req_ready, .req, .rsp_valid, .pins,
    .data_lines_out, .data_lines_oe);
`default_nettype wire

// ==== verification/sram_ctrl_test.sv ====
// self-checking bench for the async sram controller against a memory model
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_test
    import sram_ctrl_pkg::*;
();
    logic              ref_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              req_valid = 1'b0;
    req_type           req = '0;
    logic              req_ready, rsp_valid;
    logic [DATA_W-1:0] rsp_rdata, bus_in, bus_out;
    logic [1:0]        bus_oe;
    pins_type          pins;
    logic [7:0]        clash;
    logic [31:0]       seed = 32'h0000DEBD;
    logic [15:0]       shadow [logic [ADDR_W-1:0]];
    int                bad_count = 0;
    int                num_checks = 0;
    always #5 ref_clk = ~ref_clk;
    sram_ctrl dut (.ref_clk, .rstn, .req_valid, .req_ready, .req, .rsp_valid, .rsp_rdata, .pins,
        .data_lines_in(bus_in), .data_lines_out(bus_out), .data_lines_oe(bus_oe));
    sram_model mem_model (.pins, .data_lines_out(bus_out), .data_lines_oe(bus_oe), .data_lines_in(bus_in),
        .clash_count(clash));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] lane_mask(input logic [1:0] l);
        return {{8{l[1]}}, {8{l[0]}}};
    endfunction
    // small address pool at both ends of the range keeps every read known
    function automatic logic [ADDR_W-1:0] pool(input logic [3:0] k);
        return k[3] ? 17'h1FFFF - 17'(k[2:0]) : 17'(k[2:0]);
    endfunction
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // request held until taken; a read then waits a bounded time for its answer
    task automatic access(input logic wr, input logic [1:0] l, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{wr, l, a, d};
        do @(posedge ref_clk); while (req_ready !== 1'b1 && ++n < 50);
        req_valid <= 1'b0;
        if (n >= 50) bad_count++;
        if (wr) shadow[a] = (shadow[a] & ~lane_mask(l)) | (d & lane_mask(l));
        else begin
            n = 0;
            do begin @(posedge ref_clk); #1; n++; end while (rsp_valid !== 1'b1 && n < 50);
            check16(16'(n), 16'(READ_ACCESS_CYC + 3));
            check16(rsp_rdata, shadow[a] & lane_mask(l));
        end
    endtask
    // main sequence: reset, fill, lane corners, random traffic
    initial begin
        repeat (8) @(posedge ref_clk);
        check16({12'h000, pins.chip_select_n, pins.write_strobe_n, bus_oe}, 16'h000C);
        rstn <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            shadow[pool(4'(k))] = 16'h0000;
            access(1'b1, 2'b11, pool(4'(k)), seed[15:0]);
        end
        $display("test fill done");
        for (int l = 1; l < 4; l++) begin
            access(1'b1, 2'(l), 17'h1FFFF, 16'hC3A5 ^ 16'(l));
            access(1'b0, 2'(l), 17'h1FFFF, 16'h0000);
            access(1'b0, 2'b11, 17'h1FFFF, 16'h0000);
        end
        $display("test lanes done");
        repeat (80) begin
            seed = xs(seed);
            access(seed[20], seed[22:21] == 2'b00 ? 2'b11 : seed[22:21], pool(seed[3:0]), seed[31:16]);
        end
        $display("test random done");
        check16(16'(clash), 16'h0000);
        close_out();
    end
    // watchdog: the run needs about 1000 cycles
    initial begin
        #(20000 * CLK_PERIOD_NS);
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire

// ==== verification/sram_model.sv ====
// behavioural x16 async sram standing on the controller's pins
`timescale 1ns/1ps
`default_nettype none
module sram_model
    import sram_ctrl_pkg::*;
(
    input  wire pins_type          pins,
    input  wire logic [DATA_W-1:0] data_lines_out,
    input  wire logic [1:0]        data_lines_oe,
    output logic [DATA_W-1:0]      data_lines_in,
    output logic [7:0]             clash_count
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rd_q = 16'h0000;
    logic [DATA_W-1:0] junk = 16'h5A3C;
    logic [1:0]        drv = 2'b00;
    pins_type          p_d;
    logic [DATA_W-1:0] bus_d;
    wire               rd_ok = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n;
    wire [1:0]         want = {!pins.high_byte_lane_enable_n, !pins.low_byte_lane_enable_n} & {2{rd_ok}};
    wire               writing = !pins.chip_select_n && !pins.write_strobe_n;
    wire [DATA_W-1:0]  dm = {{8{drv[1]}}, {8{drv[0]}}};
    wire [DATA_W-1:0]  om = {{8{data_lines_oe[1]}}, {8{data_lines_oe[0]}}};
    initial clash_count = 8'h00;
    // lanes nobody drives wander, so a stale value never passes for data
    always #7 junk = {junk[14:0], ~junk[15]};
    assign #1 p_d = pins;
    assign #1 bus_d = data_lines_in;
    // release at once, turn on only after 5 ns, so release always beats turn-on
    always @(want) begin
        drv <= drv & want;
        drv <= #5 want;
    end
    // old word holds 10 ns, then garbage until the access time runs out
    always @(pins.addr or negedge pins.chip_select_n) begin
        rd_q <= #10 ~rd_q;
        rd_q <= #(CS_ACCESS_NS) mem[pins.addr];
    end
    assign data_lines_in = (rd_q & dm) | (data_lines_out & om) | (junk & ~dm & ~om);
    // the word lands at the end of the overlap, from values just before it
    always @(negedge writing) begin
        if (!p_d.low_byte_lane_enable_n) mem[p_d.addr][7:0] = bus_d[7:0];
        if (!p_d.high_byte_lane_enable_n) mem[p_d.addr][15:8] = bus_d[15:8];
    end
    // both sides driving one lane is counted
    always @(drv or data_lines_oe) if (|(drv & data_lines_oe)) clash_count++;
endmodule
`default_nettype wire
